// File: verif/flash_reset_qpi_exit_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module flash_reset_qpi_exit_tb;
  import frqx_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, quad_enable = 1'b0, op_running = 1'b0;
  logic erase_running = 1'b0, vol_load = 1'b0, vol_write_enable = 1'b0, vol_suspend = 1'b0;
  logic vol_deep_pd = 1'b0, cmd_valid = 1'b0, reset_req = 1'b0;
  logic status_busy = 1'b0, status_suspend = 1'b0;
  logic [7:0] vol_read_param = 8'h00, vol_cont_mode = 8'h00, vol_status = 8'h00;
  logic [7:0] cmd_code = 8'h00;
  logic [2:0] vol_wrap = 3'h0;
  logic four_wire_command_mode, recovering, abort_pulse, data_suspect, write_enable_latch;
  logic suspend_flag, deep_power_down, ready, done, reset_refused, h_mode, mode_b, recovering_b;
  logic [7:0] read_parameter_bits, continuous_read_mode_bits, status_bits, erased_byte;
  logic [7:0] last_opcode, last_b, sh1, sh4;
  logic [2:0] wrap_setting_bits;
  logic sk;
  int num_errors = 0, comparisons = 0, rec_cnt = 0, abort_cnt = 0, ref_cnt = 0;
  wire [30:0] vol_all = {four_wire_command_mode, write_enable_latch, suspend_flag,
    read_parameter_bits, deep_power_down, continuous_read_mode_bits, wrap_setting_bits,
    status_bits};
  frqx_link_if link_a();
  frqx_link_if link_b();
  frqx_host #(.RST_E_CYCLES(200)) frqx_host_i (.link(link_a), .four_wire_command_mode(h_mode), .*);
  frqx_device #(.RST_E_CYCLES(200)) frqx_device_i (.link(link_a), .*);
  // second device faces the bench driver, which breaks the host's side on purpose
  frqx_device #(.RST_E_CYCLES(200)) frqx_device_b_i (.link(link_b), .four_wire_command_mode(mode_b),
    .recovering(recovering_b), .abort_pulse(), .data_suspect(), .write_enable_latch(),
    .suspend_flag(), .read_parameter_bits(), .deep_power_down(), .continuous_read_mode_bits(),
    .wrap_setting_bits(), .status_bits(), .erased_byte(), .last_opcode(last_b), .*);
  frqx_checker frqx_checker_i (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(link_a.cs_n),
    .sclk(link_a.sclk), .dq(link_a.dq));
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    sk <= link_a.sclk;
    if (link_a.sclk && !sk && !link_a.cs_n) begin
      sh1 <= {sh1[6:0], link_a.dq[0]};
      sh4 <= {sh4[3:0], link_a.dq};
    end
    rec_cnt <= rec_cnt + int'(recovering);
    abort_cnt <= abort_cnt + int'(abort_pulse);
    ref_cnt <= ref_cnt + int'(reset_refused);
  end
  function automatic int exp_rec(input logic e);
    return e ? 200 : FRQX_RST_CYC;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic load();
    {vol_write_enable, vol_suspend, vol_read_param, vol_deep_pd, vol_cont_mode, vol_wrap,
      vol_status} = 30'($urandom);
    vol_load = 1'b1;
    @(negedge ref_clk);
    vol_load = 1'b0;
  endtask
  task automatic op(input logic rq, input logic [7:0] code);
    logic m;
    int n;
    m = h_mode;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    rec_cnt = 0;
    abort_cnt = 0;
    cmd_code = code;
    reset_req = rq;
    cmd_valid = !rq;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    reset_req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 8000) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(done, 1'b1)
    `CHK(m ? sh4 : sh1, rq ? FRQX_OP_RST : code)
  endtask
  // no spacing check here: the driver keeps the link gaps by construction
  task automatic frame(input logic [7:0] c);
    link_b.cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      link_b.dq = {3'h0, c[i]};
      repeat (4) @(negedge ref_clk);
      link_b.sclk = 1'b1;
      repeat (4) @(negedge ref_clk);
      link_b.sclk = 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    link_b.cs_n = 1'b1;
    link_b.dq = ~link_b.dq;
    repeat (6) @(negedge ref_clk);
  endtask
  initial begin
    #500000;
    num_errors++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.dq = 4'h0;
    void'($urandom(32'h983F59FB));
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    `CHK(status_bits, FRQX_STATUS_SHIP)
    `CHK(erased_byte, FRQX_ERASED_BYTE)
    quad_enable = 1'b1;
    for (int k = 0; k < 3; k++) begin
      load();
      op(1'b0, FRQX_OP_ENTER_4W);
      `CHK(four_wire_command_mode, 1'b1)
      op(1'b0, FRQX_OP_EXIT_4W);
      `CHK({four_wire_command_mode, h_mode}, 2'b00)
      `CHK(vol_all[29:28], {vol_write_enable, vol_suspend})
      `CHK(wrap_setting_bits, vol_wrap)
      if (k == 1) op(1'b0, FRQX_OP_ENTER_4W);
      op_running = 1'($urandom);
      erase_running = (k == 2);
      load();
      op(1'b1, 8'h00);
      `CHK(abort_cnt, 1)
      `CHK(rec_cnt >= exp_rec(erase_running) && rec_cnt <= exp_rec(erase_running) + 1, 1'b1)
      `CHK(vol_all, 31'h0)
      `CHK(data_suspect, op_running | erase_running | vol_suspend)
      `CHK({last_opcode, h_mode}, {FRQX_OP_RST, 1'b0})
    end
    for (int j = 0; j < 2; j++) begin
      status_busy = (j == 0);
      status_suspend = (j == 1);
      @(negedge ref_clk);
      ref_cnt = 0;
      abort_cnt = 0;
      reset_req = 1'b1;
      @(negedge ref_clk);
      reset_req = 1'b0;
      repeat (40) @(negedge ref_clk);
      `CHK({ref_cnt, abort_cnt}, {32'sd1, 32'sd0})
    end
    quad_enable = 1'b0;
    frame(FRQX_OP_ENTER_4W);
    `CHK(mode_b, 1'b0)
    quad_enable = 1'b1;
    frame(FRQX_OP_RST);
    frame(FRQX_OP_RST_EN);
    frame({2'b11, 6'($urandom)});
    frame(FRQX_OP_RST);
    `CHK(recovering_b, 1'b0)
    frame(FRQX_OP_RST_EN);
    frame(FRQX_OP_RST);
    `CHK(recovering_b, 1'b1)
    frame(FRQX_OP_ENTER_4W);
    `CHK({mode_b, last_b}, {1'b0, FRQX_OP_RST})
    wrap_up();
  end
endmodule

// File: verif/frqx_assertions.sv
`timescale 1ns/1ps
module frqx_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] dq
);
  logic sclk_q;
  logic [3:0] rise_q;
  // rises counted per frame; cleared whenever chip select is high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      rise_q <= 4'h0;
    end else begin
      sclk_q <= sclk;
      rise_q <= cs_n ? 4'h0 : rise_q + {3'h0, sclk & ~sclk_q};
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_low3;
    !sclk [*3];
  endsequence
  property p_idle_clk; cs_n |-> !sclk; endproperty
  property p_high3; $rose(sclk) |-> sclk [*3]; endproperty
  property p_low3; $fell(sclk) |-> s_low3; endproperty
  property p_gap; $rose(cs_n) |-> cs_n [*3]; endproperty
  property p_setup; $fell(cs_n) |-> s_low3; endproperty
  property p_dq_hold; sclk && $past(sclk) |-> $stable(dq); endproperty
  property p_frame_len; $rose(cs_n) |-> (rise_q == 4'h8 || rise_q == 4'h2); endproperty
  property p_tail; $rose(cs_n) |-> !$past(sclk) && !$past(sclk, 2); endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock outside frame");
  a_high3: assert property (p_high3) else $error("clock high too short");
  a_low3: assert property (p_low3) else $error("clock low too short");
  a_gap: assert property (p_gap) else $error("select gap too short");
  a_setup: assert property (p_setup) else $error("select setup too short");
  a_dq_hold: assert property (p_dq_hold) else $error("data moved while clock high");
  a_frame_len: assert property (p_frame_len) else $error("frame not one opcode");
  a_tail: assert property (p_tail) else $error("select rose too soon");
endmodule

// File: verilog/frqx_device.sv
`timescale 1ns/1ps
module frqx_device #(
  parameter int RST_E_CYCLES = frqx_pkg::FRQX_RST_E_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  frqx_link_if.dev link,
  input wire logic quad_enable,
  input wire logic op_running,
  input wire logic erase_running,
  input wire logic vol_load,
  input wire logic vol_write_enable,
  input wire logic vol_suspend,
  input wire logic [7:0] vol_read_param,
  input wire logic vol_deep_pd,
  input wire logic [7:0] vol_cont_mode,
  input wire logic [2:0] vol_wrap,
  input wire logic [7:0] vol_status,
  output logic four_wire_command_mode,
  output logic recovering,
  output logic abort_pulse,
  output logic data_suspect,
  output logic write_enable_latch,
  output logic suspend_flag,
  output logic [7:0] read_parameter_bits,
  output logic deep_power_down,
  output logic [7:0] continuous_read_mode_bits,
  output logic [2:0] wrap_setting_bits,
  output logic [7:0] status_bits,
  output logic [7:0] erased_byte,
  output logic [7:0] last_opcode
);
  import frqx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage 1 is read only by stage 2
  logic [2:0] cs_sync_q;
  logic [2:0] sclk_sync_q;
  logic [3:0] dq_s1_q;
  logic [3:0] dq_s2_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_q <= 3'h7;
      sclk_sync_q <= 3'h0;
      dq_s1_q <= 4'h0;
      dq_s2_q <= 4'h0;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], link.cs_n};
      sclk_sync_q <= {sclk_sync_q[1:0], link.sclk};
      dq_s1_q <= link.dq;
      dq_s2_q <= dq_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame capture
  logic four_wire_q;
  logic [7:0] shift_q;
  logic [3:0] bits_q;
  logic rst_en_q;
  logic busy_q;
  logic [FRQX_WAIT_W-1:0] timer_q;

  wire cs_low = !cs_sync_q[1];
  wire cs_fall = cs_sync_q[2] && !cs_sync_q[1];
  wire cs_rise = cs_sync_q[1] && !cs_sync_q[2];
  wire sclk_rise = cs_low && sclk_sync_q[1] && !sclk_sync_q[2];
  wire byte_open = bits_q < 4'(FRQX_BYTE_BITS);
  wire [3:0] bit_step = four_wire_q ? 4'h4 : 4'h1;
  wire [7:0] shift_next = four_wire_q ? {shift_q[3:0], dq_s2_q} : {shift_q[6:0], dq_s2_q[0]};
  // frames that end while recovering are dropped whole
  wire frame_done = cs_rise && !busy_q;
  wire byte_ok = bits_q == 4'(FRQX_BYTE_BITS);
  wire op_exit = byte_ok && shift_q == FRQX_OP_EXIT_4W && four_wire_q;
  wire op_enter = byte_ok && shift_q == FRQX_OP_ENTER_4W && !four_wire_q && quad_enable;
  wire op_rst_en = byte_ok && shift_q == FRQX_OP_RST_EN;
  wire op_rst = byte_ok && shift_q == FRQX_OP_RST;
  wire reset_fire = frame_done && op_rst && rst_en_q;
  wire timer_zero = timer_q == '0;
  wire [FRQX_WAIT_W-1:0] rst_short = FRQX_WAIT_W'(FRQX_RST_CYC - 1);
  wire [FRQX_WAIT_W-1:0] rst_long = FRQX_WAIT_W'(RST_E_CYCLES - 1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
      bits_q <= 4'h0;
    end else if (cs_fall) begin
      shift_q <= 8'h00;
      bits_q <= 4'h0;
    end else if (sclk_rise && byte_open) begin
      shift_q <= shift_next;
      bits_q <= bits_q + bit_step;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode, reset arming and recovery timer
  logic abort_q;
  logic suspect_q;
  logic [7:0] last_op_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      four_wire_q <= 1'b0;
      rst_en_q <= 1'b0;
      busy_q <= 1'b0;
      timer_q <= '0;
      abort_q <= 1'b0;
      suspect_q <= 1'b0;
      last_op_q <= 8'h00;
    end else begin
      abort_q <= reset_fire;
      if (busy_q) begin
        if (timer_zero) begin
          busy_q <= 1'b0;
        end else begin
          timer_q <= timer_q - 1'b1;
        end
      end
      if (frame_done) begin
        last_op_q <= shift_q;
        // any other frame, or a partial one, drops a pending enable
        rst_en_q <= op_rst_en;
      end
      if (reset_fire) begin
        four_wire_q <= 1'b0;
        busy_q <= 1'b1;
        timer_q <= erase_running ? rst_long : rst_short;
        // an interrupted or suspended write leaves its target undefined
        suspect_q <= op_running || erase_running || suspend_flag;
      end else if (frame_done && op_exit) begin
        four_wire_q <= 1'b0;
      end else if (frame_done && op_enter) begin
        four_wire_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // volatile state; leaving four-wire mode touches none of it
  logic latch_q;
  logic susp_q;
  logic [7:0] param_q;
  logic dpd_q;
  logic [7:0] mode_q;
  logic [2:0] wrap_q;
  logic [7:0] status_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
      susp_q <= 1'b0;
      param_q <= 8'h00;
      dpd_q <= 1'b0;
      mode_q <= 8'h00;
      wrap_q <= 3'h0;
      status_q <= FRQX_STATUS_SHIP;
    end else if (reset_fire) begin
      latch_q <= 1'b0;
      susp_q <= 1'b0;
      param_q <= 8'h00;
      dpd_q <= 1'b0;
      mode_q <= 8'h00;
      wrap_q <= 3'h0;
      status_q <= FRQX_STATUS_SHIP;
    end else if (vol_load && !busy_q) begin
      // mode change frames never load here, so these survive an exit
      latch_q <= vol_write_enable;
      susp_q <= vol_suspend;
      param_q <= vol_read_param;
      dpd_q <= vol_deep_pd;
      mode_q <= vol_cont_mode;
      wrap_q <= vol_wrap;
      status_q <= vol_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  logic [7:0] erased_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      erased_q <= FRQX_ERASED_BYTE;
    end else begin
      erased_q <= FRQX_ERASED_BYTE;
    end
  end

  assign four_wire_command_mode = four_wire_q;
  assign recovering = busy_q;
  assign abort_pulse = abort_q;
  assign data_suspect = suspect_q;
  assign write_enable_latch = latch_q;
  assign suspend_flag = susp_q;
  assign read_parameter_bits = param_q;
  assign deep_power_down = dpd_q;
  assign continuous_read_mode_bits = mode_q;
  assign wrap_setting_bits = wrap_q;
  assign status_bits = status_q;
  assign erased_byte = erased_q;
  assign last_opcode = last_op_q;
endmodule

// File: verilog/frqx_host.sv
`timescale 1ns/1ps
module frqx_host #(
  parameter int SCLK_HALF = frqx_pkg::FRQX_SCLK_HALF_CYC,
  parameter int GAP_CYCLES = 2 * frqx_pkg::FRQX_SHSL_CYC + 4,
  parameter int RST_E_CYCLES = frqx_pkg::FRQX_RST_E_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  frqx_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic reset_req,
  input wire logic status_busy,
  input wire logic status_suspend,
  input wire logic erase_running,
  output logic ready,
  output logic done,
  output logic reset_refused,
  output logic four_wire_command_mode
);
  import frqx_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_GAP, H_RECOV} frqx_hstate_type;

  function automatic logic [3:0] frqx_lead_dq(input logic [7:0] b, input logic four_wire);
    frqx_lead_dq = four_wire ? b[7:4] : {3'h0, b[7]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  frqx_hstate_type st_q;
  logic [FRQX_WAIT_W-1:0] cnt_q;
  logic [3:0] bits_q;
  logic [7:0] sh_q;
  logic [7:0] op_q;
  logic second_q;
  logic rst_sent_q;
  logic long_q;
  logic cs_n_q;
  logic sclk_q;
  logic [3:0] dq_q;
  logic four_wire_q;
  logic ready_q;
  logic done_q;
  logic refused_q;

  wire cnt_zero = cnt_q == '0;
  wire [FRQX_WAIT_W-1:0] half_load = FRQX_WAIT_W'(SCLK_HALF - 1);
  wire [FRQX_WAIT_W-1:0] gap_load = FRQX_WAIT_W'(GAP_CYCLES - 1);
  wire [FRQX_WAIT_W-1:0] rec_load = long_q ? FRQX_WAIT_W'(RST_E_CYCLES - 1)
                                           : FRQX_WAIT_W'(FRQX_RST_CYC - 1);
  wire [3:0] step = four_wire_q ? 4'h4 : 4'h1;
  wire [7:0] sh_next = four_wire_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
  // status must show idle before the reset pair is sent
  wire reset_ok = !status_busy && !status_suspend;
  wire reset_go = reset_req && reset_ok;
  wire start_any = ready_q && (cmd_valid || reset_go);
  // a refused reset must never turn a plain command into the reset pair
  wire [7:0] start_code = reset_go ? FRQX_OP_RST_EN : cmd_code;
  wire start_now = start_any || (st_q == H_GAP && cnt_zero && second_q);
  wire [7:0] code_now = start_any ? start_code : FRQX_OP_RST;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= H_IDLE;
      cnt_q <= '0;
      bits_q <= 4'h0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      second_q <= 1'b0;
      rst_sent_q <= 1'b0;
      long_q <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      dq_q <= 4'h0;
      four_wire_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      refused_q <= ready_q && reset_req && !reset_ok;
      if (start_now) begin
        // each opcode gets a frame of its own
        sh_q <= code_now;
        op_q <= code_now;
        cs_n_q <= 1'b0;
        dq_q <= frqx_lead_dq(code_now, four_wire_q);
        bits_q <= step;
        cnt_q <= half_load;
        ready_q <= 1'b0;
        st_q <= H_LEAD;
        if (start_any) begin
          second_q <= reset_go;
          rst_sent_q <= 1'b0;
          long_q <= erase_running;
        end else begin
          second_q <= 1'b0;
          rst_sent_q <= 1'b1;
        end
      end else begin
        unique case (st_q)
          H_IDLE: begin
            ready_q <= 1'b1;
          end
          H_LEAD: begin
            if (cnt_zero) begin
              sclk_q <= 1'b1;
              cnt_q <= half_load;
              st_q <= H_HIGH;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          H_HIGH: begin
            if (cnt_zero) begin
              sclk_q <= 1'b0;
              sh_q <= sh_next;
              // data moves on the fall so it is settled half a period before the rise
              dq_q <= frqx_lead_dq(sh_next, four_wire_q);
              cnt_q <= half_load;
              st_q <= H_LOW;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          H_LOW: begin
            if (!cnt_zero) begin
              cnt_q <= cnt_q - 1'b1;
            end else if (bits_q == 4'(FRQX_BYTE_BITS)) begin
              // frame closes with chip select high
              cs_n_q <= 1'b1;
              cnt_q <= gap_load;
              st_q <= H_GAP;
              if (op_q == FRQX_OP_EXIT_4W) begin
                four_wire_q <= 1'b0;
              end else if (op_q == FRQX_OP_ENTER_4W) begin
                four_wire_q <= 1'b1;
              end
            end else begin
              bits_q <= bits_q + step;
              sclk_q <= 1'b1;
              cnt_q <= half_load;
              st_q <= H_HIGH;
            end
          end
          H_GAP: begin
            if (!cnt_zero) begin
              cnt_q <= cnt_q - 1'b1;
            end else if (rst_sent_q) begin
              four_wire_q <= 1'b0;
              cnt_q <= rec_load;
              st_q <= H_RECOV;
            end else begin
              done_q <= 1'b1;
              st_q <= H_IDLE;
            end
          end
          H_RECOV: begin
            // no traffic until the device has recovered
            if (cnt_zero) begin
              done_q <= 1'b1;
              rst_sent_q <= 1'b0;
              st_q <= H_IDLE;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
        endcase
      end
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.dq = dq_q;
  assign ready = ready_q;
  assign done = done_q;
  assign reset_refused = refused_q;
  assign four_wire_command_mode = four_wire_q;
endmodule

// File: verilog/frqx_link_if.sv
`timescale 1ns/1ps
interface frqx_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] dq;
  modport dev (input cs_n, input sclk, input dq);
  modport host (output cs_n, output sclk, output dq);
endinterface

// File: verilog/frqx_pkg.sv
package frqx_pkg;
  // opcodes seen on the link
  localparam logic [7:0] FRQX_OP_EXIT_4W = 8'hFF;
  localparam logic [7:0] FRQX_OP_ENTER_4W = 8'h38;
  localparam logic [7:0] FRQX_OP_RST_EN = 8'h66;
  localparam logic [7:0] FRQX_OP_RST = 8'h99;
  // shipped contents
  localparam logic [7:0] FRQX_ERASED_BYTE = 8'hFF;
  localparam logic [7:0] FRQX_STATUS_SHIP = 8'h00;
  // clock and recovery times
  localparam int FRQX_CLK_MHZ = 100;
  localparam int FRQX_T_RST_US = 30;
  localparam int FRQX_T_RST_E_MS = 12;
  localparam int FRQX_RST_CYC = FRQX_T_RST_US * FRQX_CLK_MHZ;
  localparam int FRQX_RST_E_CYC = FRQX_T_RST_E_MS * 1000 * FRQX_CLK_MHZ;
  localparam int FRQX_T_SHSL_NS = 20;
  localparam int FRQX_SHSL_CYC = (FRQX_T_SHSL_NS * FRQX_CLK_MHZ + 999) / 1000;
  localparam int FRQX_SCLK_HALF_CYC = 4;
  localparam int FRQX_WAIT_W = 21;
  localparam int FRQX_BYTE_BITS = 8;
endpackage
